// >>> hdl/period_timer.sv
// Purpose: One 8-bit period timer with prescaler and 10-bit time base
// Assumes: run_in is already synchronised to mclk_in
// Notes: Counts once per four clocks times the prescale ratio
`timescale 1ns/1ps
`include "pwm_regs.svh"

module period_timer (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Control
    input wire logic run_in,
    input wire logic on_in,
    input wire pwm_pkg::presc_t prescale_in,
    input wire pwm_pkg::byte_t period_in,
    // Software write of the count
    input wire logic count_we_in,
    input wire pwm_pkg::byte_t count_wdata_in,
    // Status
    output pwm_pkg::byte_t count_out,
    output pwm_pkg::base_t time_base_out,
    output logic roll_out,
    output logic advance_out
);

    logic [1:0] phase_reg;
    logic [3:0] presc_reg;
    pwm_pkg::byte_t count_reg;
    logic tick;
    logic step;

    // Prescaler terminal count for the chosen ratio
    function automatic logic presc_done(input logic [3:0] p,
                                        input pwm_pkg::presc_t sel);
        case (sel)
            `PRESC_1: presc_done = 1'b1;
            `PRESC_4: presc_done = (p[1:0] == `PHASE_LAST);
            default: presc_done = (p == `PRESC_LAST);
        endcase
    endfunction : presc_done

    // Frozen while asleep or switched off
    assign tick = run_in & on_in;
    assign step = tick & (phase_reg == `PHASE_LAST) &
                  presc_done(presc_reg, prescale_in);
    assign roll_out = step & (count_reg == period_in);
    assign count_out = count_reg;

    // Low bits of the time base follow the prescale ratio
    always_comb begin
        case (prescale_in)
            `PRESC_1: time_base_out = {count_reg, phase_reg};
            `PRESC_4: time_base_out = {count_reg, presc_reg[1:0]};
            default: time_base_out = {count_reg, presc_reg[3:2]};
        endcase
    end

    // High when the time base moves on at the next edge
    always_comb begin
        case (prescale_in)
            `PRESC_1: advance_out = tick;
            `PRESC_4: advance_out = tick & (phase_reg == `PHASE_LAST);
            default: advance_out = tick & (phase_reg == `PHASE_LAST) &
                                   (presc_reg[1:0] == `PHASE_LAST);
        endcase
    end

    // System clock phase, four per timer clock
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_reg <= 2'h0;
        end else if (count_we_in) begin
            phase_reg <= 2'h0;
        end else if (tick) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // Prescaler
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            presc_reg <= 4'h0;
        end else if (count_we_in) begin
            presc_reg <= 4'h0;
        end else if (tick && phase_reg == `PHASE_LAST) begin
            presc_reg <= presc_reg + 4'h1;
        end
    end

    // Timer count, cleared on the increment after the period match
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= `RST_BYTE;
        end else if (count_we_in) begin
            count_reg <= count_wdata_in;
        end else if (step) begin
            count_reg <= roll_out ? 8'h00 : count_reg + 8'h01;
        end
    end

    AST_STEP_PHASE: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        step |=> !step [*3])
        else $error("timer stepped sooner than four clocks");

endmodule : period_timer

// >>> hdl/pwm_generator.sv
//----------------------------------------------------------------------
// Purpose: Standard single-output pulse-width modulator with APB slave
// Assumes: 100 MHz mclk_in; sleep_in comes from outside the clock domain
// Notes: Zero-wait APB slave; unmapped addresses answer pslverr
//----------------------------------------------------------------------
// Overview of operation
// - Period comes from one of three timers chosen by a 2-bit select
// - Period is (period value + 1) times 4 clocks times prescale
// - After count equals period, timer clears and duty is latched
// - Pin goes high at rollover unless the duty value is zero
// - The timer postscaler has no effect on the output
// - Duty is 10 bits: duty-low register high, control bits 5:4 low
// - Duty fields write any time; new value applies at rollover
// - Active duty register is read-only while modulating
// - High time is duty times one clock times prescale
// - Duty is double buffered by active register and hidden latch
// - Time base is count plus clock phase or prescaler bits
// - Pin goes low when time base equals the latched duty
// - Resolution is log2 of 4 times (period + 1), ten bits at most
// - A pulse longer than the period leaves the pin unchanged
// - In sleep the timer and state hold, pin keeps its level
// - Reset makes the pin an input and registers their defaults
// - Output frequency scales directly with the system clock
// - Control register zero returns the pin to port use
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "pwm_regs.svh"

module pwm_generator (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Power state
    input wire logic sleep_in,
    // Output pin
    output logic pwm_output_pin_out,
    output logic pwm_output_pin_oe_b_out
);

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    pwm_pkg::byte_t pwm_control_reg;
    logic [1:0] timer_selection_reg;
    pwm_pkg::byte_t duty_low_reg;
    pwm_pkg::byte_t active_duty_reg;
    logic [1:0] fraction_latch_reg;
    logic [1:0] pin_port_reg;
    pwm_pkg::byte_t period_value_reg [`NUM_TIMERS];
    logic [6:0] timer_control_reg [`NUM_TIMERS];
    logic out_reg;
    logic [31:0] prdata_reg;
    logic sleep_meta_reg;
    logic sleep_sync_reg;

    pwm_pkg::byte_t tmr_count [`NUM_TIMERS];
    pwm_pkg::base_t tmr_base [`NUM_TIMERS];
    logic [`NUM_TIMERS-1:0] tmr_roll;
    logic [`NUM_TIMERS-1:0] tmr_count_we;
    logic [`NUM_TIMERS-1:0] tmr_adv;
    pwm_pkg::base_t next_base;

    logic setup;
    logic wr_en;
    logic addr_ok;
    logic [31:0] rdata_next;
    logic tmr_hit;
    logic [1:0] tmr_idx;
    logic [1:0] sel;
    logic pwm_on;
    logic run;
    logic roll;
    logic match;
    pwm_pkg::byte_t sel_count;
    pwm_pkg::base_t sel_base;
    pwm_pkg::base_t buffered;
    pwm_pkg::base_t active_full;

    //------------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------------
    // Timer block index from the address, 0 when not a timer address
    function automatic logic [1:0] timer_index(input logic [11:0] a);
        if (a[11:6] == 6'h00 && a[5:4] != 2'h0) begin
            timer_index = a[5:4] - 2'h1;
        end else begin
            timer_index = 2'h0;
        end
    endfunction : timer_index

    // True when the address lands in a timer block
    function automatic logic timer_hit(input logic [11:0] a);
        timer_hit = a[11:6] == 6'h00 && a[5:4] != 2'h0 &&
                    a[3:2] != 2'h3 && a[1:0] == 2'h0;
    endfunction : timer_hit

    assign setup = psel_in & ~penable_in;
    assign wr_en = psel_in & penable_in & pwrite_in & addr_ok;
    assign tmr_hit = timer_hit(paddr_in);
    assign tmr_idx = timer_index(paddr_in);

    // Read mux and address check
    always_comb begin
        rdata_next = 32'h0;
        addr_ok = 1'b1;
        if (tmr_hit) begin
            case (paddr_in[3:2])
                `TMR_SUB_PERIOD: rdata_next[7:0] =
                    period_value_reg[tmr_idx];
                `TMR_SUB_CONTROL: rdata_next[6:0] =
                    timer_control_reg[tmr_idx];
                default: rdata_next[7:0] = tmr_count[tmr_idx];
            endcase
        end else begin
            case (paddr_in)
                `OFS_PWM_CONTROL: rdata_next[5:0] = pwm_control_reg[5:0];
                `OFS_TIMER_SELECTION: rdata_next[1:0] =
                    timer_selection_reg;
                `OFS_DUTY_LOW: rdata_next[7:0] = duty_low_reg;
                `OFS_ACTIVE_DUTY: rdata_next[7:0] = active_duty_reg;
                `OFS_PIN_PORT: rdata_next[1:0] = pin_port_reg;
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // Zero-wait answer; error flagged in the access phase
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_ok;
    assign prdata_out = prdata_reg;

    // Read data captured in the setup phase
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_reg <= 32'h0;
        end else if (setup && !pwrite_in) begin
            prdata_reg <= rdata_next;
        end
    end

    //------------------------------------------------------------------
    // Software registers
    //------------------------------------------------------------------
    // Control, timer selection, duty low and pin port
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pwm_control_reg <= `RST_BYTE;
            timer_selection_reg <= 2'h0;
            duty_low_reg <= `RST_BYTE;
            pin_port_reg <= `RST_PIN_PORT;
        end else if (wr_en && !tmr_hit) begin
            case (paddr_in)
                `OFS_PWM_CONTROL: pwm_control_reg <=
                    {2'h0, pwdata_in[5:0]};
                `OFS_TIMER_SELECTION: timer_selection_reg <=
                    pwdata_in[1:0];
                `OFS_DUTY_LOW: duty_low_reg <= pwdata_in[7:0];
                `OFS_PIN_PORT: pin_port_reg <= pwdata_in[1:0];
                default: pin_port_reg <= pin_port_reg;
            endcase
        end
    end

    // Per-timer period and control registers
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < `NUM_TIMERS; i++) begin
                period_value_reg[i] <= `RST_PERIOD;
                timer_control_reg[i] <= 7'h00;
            end
        end else if (wr_en && tmr_hit) begin
            if (paddr_in[3:2] == `TMR_SUB_PERIOD) begin
                period_value_reg[tmr_idx] <= pwdata_in[7:0];
            end else if (paddr_in[3:2] == `TMR_SUB_CONTROL) begin
                timer_control_reg[tmr_idx] <= pwdata_in[6:0];
            end
        end
    end

    // Count write strobes, one per timer
    always_comb begin
        tmr_count_we = '0;
        if (wr_en && tmr_hit && paddr_in[3:2] == `TMR_SUB_COUNT) begin
            tmr_count_we[tmr_idx] = 1'b1;
        end
    end

    //------------------------------------------------------------------
    // Sleep synchroniser
    //------------------------------------------------------------------
    // Two flip-flops before any logic sees the sleep request
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sleep_meta_reg <= 1'b0;
            sleep_sync_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_in;
            sleep_sync_reg <= sleep_meta_reg;
        end
    end

    assign run = ~sleep_sync_reg;

    //------------------------------------------------------------------
    // Period timers
    //------------------------------------------------------------------
    // Postscale bits are stored only; the timers never use them
    for (genvar g = 0; g < `NUM_TIMERS; g++) begin : g_tmr
        period_timer u_timer (
            .mclk_in(mclk_in),
            .rst_b_in(rst_b_in),
            .run_in(run),
            .on_in(timer_control_reg[g][2]),
            .prescale_in(timer_control_reg[g][1:0]),
            .period_in(period_value_reg[g]),
            .count_we_in(tmr_count_we[g]),
            .count_wdata_in(pwdata_in[7:0]),
            .count_out(tmr_count[g]),
            .time_base_out(tmr_base[g]),
            .roll_out(tmr_roll[g]),
            .advance_out(tmr_adv[g])
        );
    end

    //------------------------------------------------------------------
    // Modulator
    //------------------------------------------------------------------
    // Selector value 3 falls back to the first timer
    assign sel = (timer_selection_reg == 2'h3) ? 2'h0 :
                 timer_selection_reg;
    assign sel_count = tmr_count[sel];
    assign sel_base = tmr_base[sel];
    assign pwm_on = pwm_control_reg[3:2] == `MODE_PWM_TOP;
    assign roll = pwm_on & tmr_roll[sel];
    assign buffered = {duty_low_reg, pwm_control_reg[5:4]};
    assign active_full = {active_duty_reg, fraction_latch_reg};
    // Clear on the edge at which the time base reaches the duty value,
    // so the high time is exactly duty steps long
    assign next_base = sel_base + 10'h001;
    // No match when the pulse outlasts the period, so the pin holds
    assign match = pwm_on & run & ~roll & tmr_adv[sel] &
                   (next_base == active_full);

    // Active duty and hidden latch loaded at rollover
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            active_duty_reg <= `RST_BYTE;
            fraction_latch_reg <= 2'h0;
        end else if (roll) begin
            active_duty_reg <= duty_low_reg;
            fraction_latch_reg <= pwm_control_reg[5:4];
        end else if (wr_en && !pwm_on && paddr_in == `OFS_ACTIVE_DUTY) begin
            active_duty_reg <= pwdata_in[7:0];
        end
    end

    // Output level: set at rollover, cleared at the duty match
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            out_reg <= 1'b0;
        end else if (!pwm_on) begin
            out_reg <= 1'b0;
        end else if (roll) begin
            out_reg <= buffered != 10'h000;
        end else if (match) begin
            out_reg <= 1'b0;
        end
    end

    // Pin driven from the modulator or from the port latch
    assign pwm_output_pin_out = (pwm_control_reg == 8'h00) ?
        pin_port_reg[`PIN_DATA_BIT] : out_reg;
    assign pwm_output_pin_oe_b_out = pin_port_reg[`PIN_DIR_BIT];

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    AST_ROLL_CLEARS: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        roll && !wr_en |=> sel_count == 8'h00)
        else $error("timer not cleared after period match");

    AST_DUTY_LATCHED: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        roll |=> active_full == $past(buffered))
        else $error("duty not latched at rollover");

    AST_SET_HIGH: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        roll && buffered != 10'h000 |=> out_reg)
        else $error("output not set at rollover");

    AST_ZERO_LOW: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        roll && buffered == 10'h000 |=> !out_reg)
        else $error("output set with zero duty");

    AST_MATCH_LOW: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        match |=> !out_reg [*1] ##1 (out_reg -> $past(roll)))
        else $error("output not cleared at duty match");

    AST_ACTIVE_RO: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        pwm_on && !roll && wr_en && paddr_in == `OFS_ACTIVE_DUTY
        |=> $stable(active_duty_reg))
        else $error("active duty written while modulating");

    AST_SLEEP_HOLD: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        sleep_sync_reg && !wr_en && $past(sleep_sync_reg)
        |=> $stable(sel_count) && $stable(out_reg))
        else $error("state moved during sleep");

    AST_RELEASE: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        pwm_control_reg == 8'h00
        |-> pwm_output_pin_out == pin_port_reg[1])
        else $error("pin not returned to port use");

    AST_HIGH_ONE: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        roll && run && buffered == 10'h001 && sel_base[1:0] == 2'h3 &&
        timer_control_reg[sel][1:0] == `PRESC_1
        |=> out_reg ##1 !out_reg)
        else $error("one-step pulse not one clock wide");

    AST_MODE_OFF: assert property (@(posedge mclk_in)
        disable iff (!rst_b_in)
        !pwm_on |=> !out_reg)
        else $error("output high outside modulator mode");

    COV_ROLL_HIGH: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in) roll && buffered != 10'h000);
    COV_MATCH: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in) match && out_reg);
    COV_SLEEP: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in) sleep_sync_reg && pwm_on && out_reg);
    COV_FULL: cover property (@(posedge mclk_in)
        disable iff (!rst_b_in) roll && out_reg);

endmodule : pwm_generator

// >>> hdl/pwm_pkg.sv
// Purpose: Shared types of the pulse-width modulator
// Assumes: Constants live in pwm_regs.svh
// Notes: Types only
package pwm_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [9:0] base_t;
    typedef logic [1:0] presc_t;
endpackage : pwm_pkg

// >>> hdl/pwm_regs.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: Timer registers repeat per timer at 0x010 + index * 0x10
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_PWM_CONTROL 12'h000
`define OFS_TIMER_SELECTION 12'h004
`define OFS_DUTY_LOW 12'h008
`define OFS_ACTIVE_DUTY 12'h00c
`define OFS_PIN_PORT 12'h040
`define TMR_SUB_PERIOD 2'h0
`define TMR_SUB_CONTROL 2'h1
`define TMR_SUB_COUNT 2'h2
`define NUM_TIMERS 3

// ----------------------------------------------------------------------
// Fields and encodings
// ----------------------------------------------------------------------
`define MODE_PWM_TOP 2'h3
`define PRESC_1 2'h0
`define PRESC_4 2'h1
`define PHASE_LAST 2'h3
`define PRESC_LAST 4'hf
`define PIN_DIR_BIT 0
`define PIN_DATA_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_PERIOD 8'hff
`define RST_PIN_PORT 2'h1

`endif

// >>> tb/pwm_load.sv
// Purpose: Load on the modulator pin that times pulses and periods
// Assumes: The pin has a pull-down while it is not driven
// Notes: Lengths are clock counts between sampled edges
`timescale 1ns/1ps

module pwm_load (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Pin as the design drives it
    input wire logic pin_in,
    input wire logic oe_b_in,
    // Measurements
    output logic level_out,
    output logic [15:0] high_len_out,
    output logic [15:0] period_len_out,
    output logic [15:0] rises_out
);
    logic last_reg;
    logic [15:0] run_reg;

    // Released pin falls to the pull-down level
    assign level_out = oe_b_in ? 1'b0 : pin_in;

    // Time from each rise to the next fall and the next rise
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_reg <= 1'b0;
            run_reg <= 16'h0000;
            high_len_out <= 16'h0000;
            period_len_out <= 16'h0000;
            rises_out <= 16'h0000;
        end else begin
            last_reg <= level_out;
            run_reg <= run_reg + 16'h0001;
            if (level_out && !last_reg) begin
                period_len_out <= run_reg;
                run_reg <= 16'h0001;
                rises_out <= rises_out + 16'h0001;
            end
            if (!level_out && last_reg) begin
                high_len_out <= run_reg;
            end
        end
    end
endmodule : pwm_load

// >>> tb/tb.sv
// Purpose: Self-checking bench of the pulse-width modulator
// Assumes: Zero-wait APB slave, load model on the pin
// Notes: Each scenario is one task; a watchdog ends a hang
`timescale 1ns/1ps
`include "pwm_regs.svh"

module tb;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic sleep_in = 1'b0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, pin_out, oe_b_out, level, rd_err;
    logic [15:0] high_len, period_len, rises;
    logic [31:0] rd_data;
    int mismatches = 0;
    int check_count = 0;

    pwm_generator dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .sleep_in(sleep_in), .pwm_output_pin_out(pin_out),
        .pwm_output_pin_oe_b_out(oe_b_out));
    pwm_load load (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(pin_out),
        .oe_b_in(oe_b_out), .level_out(level), .high_len_out(high_len),
        .period_len_out(period_len), .rises_out(rises));

    // ------------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------------
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end

    initial begin
        repeat (60000) @(posedge mclk_in);
        mismatches++;
        conclude();
    end

    task conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task check(input string what, input logic [31:0] exp,
               input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; read data and error taken at the ready edge
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        rd_data = prdata_out;
        rd_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] addr, input logic [7:0] d);
        apb(1'b1, addr, {24'h0, d});
    endtask : wr

    task rd_chk(input logic [11:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 32'h0);
        check($sformatf("reg %h", addr), {24'h0, exp}, rd_data);
    endtask : rd_chk

    task wait_rises(input int n);
        logic [15:0] goal;
        // Let a rise from the old setting land before counting
        repeat (2) @(posedge mclk_in);
        goal = rises + 16'(n);
        while (rises !== goal) @(posedge mclk_in);
    endtask : wait_rises

    // Full period and high time against the formulas
    task pwm_chk(input int p, input int presc, input int duty);
        wait_rises(2);
        check("period", 32'(4 * (p + 1) * presc), {16'h0, period_len});
        check("high", 32'(duty * presc), {16'h0, high_len});
    endtask : pwm_chk

    task hold_chk(input logic exp, input int n);
        repeat (n) begin
            @(posedge mclk_in);
            check("level", {31'h0, exp}, {31'h0, level});
        end
    endtask : hold_chk

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs;
        logic [11:0] a [10];
        logic [7:0] e [10];
        a = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h040, 12'h010, 12'h014,
              12'h018, 12'h020, 12'h030};
        e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'h00, 8'hff,
              8'hff};
        check("oe_b", 32'h1, {31'h0, oe_b_out});
        foreach (a[i]) rd_chk(a[i], e[i]);
        apb(1'b0, 12'h01c, 32'h0);
        check("slverr", 32'h1, {31'h0, rd_err});
        wr(`OFS_PWM_CONTROL, 8'hff);
        rd_chk(`OFS_PWM_CONTROL, 8'h3f);
        wr(12'h014, 8'hff);
        rd_chk(12'h014, 8'h7f);
        wr(`OFS_PWM_CONTROL, 8'h00);
        wr(12'h014, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task t_timing;
        int ps [4];
        ps = '{1, 4, 16, 16};
        wr(`OFS_PIN_PORT, 8'h00);
        wr(12'h010, 8'h03);
        wr(`OFS_DUTY_LOW, 8'h01);
        wr(`OFS_PWM_CONTROL, 8'h1c);
        for (int c = 0; c < 4; c++) begin
            wr(12'h014, 8'h7c | 8'(c));
            pwm_chk(3, ps[c], 5);
        end
        wr(12'h014, 8'h04);
        wr(12'h020, 8'h01);
        wr(12'h024, 8'h04);
        wr(`OFS_TIMER_SELECTION, 8'h01);
        pwm_chk(1, 1, 5);
        wr(`OFS_TIMER_SELECTION, 8'h03);
        pwm_chk(3, 1, 5);
        wr(`OFS_TIMER_SELECTION, 8'h00);
        wr(`OFS_DUTY_LOW, 8'h00);
        pwm_chk(3, 1, 1);
        $display("test timing done");
    endtask : t_timing

    task t_edges;
        wr(`OFS_DUTY_LOW, 8'h10);
        wait_rises(1);
        hold_chk(1'b1, 40);
        wr(`OFS_DUTY_LOW, 8'h00);
        wr(`OFS_PWM_CONTROL, 8'h0c);
        repeat (20) @(posedge mclk_in);
        hold_chk(1'b0, 40);
        wr(`OFS_PWM_CONTROL, 8'h1c);
        wait_rises(1);
        wr(`OFS_PWM_CONTROL, 8'h04);
        hold_chk(1'b0, 40);
        wr(`OFS_PWM_CONTROL, 8'h00);
        wr(`OFS_PIN_PORT, 8'h02);
        hold_chk(1'b1, 2);
        wr(`OFS_PIN_PORT, 8'h03);
        hold_chk(1'b0, 2);
        check("oe_b", 32'h1, {31'h0, oe_b_out});
        $display("test edges done");
    endtask : t_edges

    task t_buffer;
        logic [31:0] c1;
        logic lv;
        wr(`OFS_PIN_PORT, 8'h00);
        wr(12'h010, 8'hff);
        wr(`OFS_DUTY_LOW, 8'h80);
        wr(`OFS_PWM_CONTROL, 8'h1c);
        pwm_chk(255, 1, 513);
        wr(`OFS_DUTY_LOW, 8'h40);
        rd_chk(`OFS_ACTIVE_DUTY, 8'h80);
        wr(`OFS_ACTIVE_DUTY, 8'h11);
        rd_chk(`OFS_ACTIVE_DUTY, 8'h80);
        wait_rises(1);
        rd_chk(`OFS_ACTIVE_DUTY, 8'h40);
        pwm_chk(255, 1, 257);
        sleep_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        apb(1'b0, 12'h018, 32'h0);
        c1 = rd_data;
        lv = level;
        hold_chk(lv, 60);
        rd_chk(12'h018, c1[7:0]);
        sleep_in <= 1'b0;
        repeat (40) @(posedge mclk_in);
        apb(1'b0, 12'h018, 32'h0);
        check("moved", 32'h1, {31'h0, rd_data !== c1});
        $display("test buffer done");
    endtask : t_buffer

    initial begin
        repeat (12) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_timing();
        t_edges();
        t_buffer();
        conclude();
    end
endmodule : tb
